// ### image_transfer_draw_coord_regs_bench.sv
// Self-checking bench for the parameter bank and its transfer sequencer.
// Assumes itd_pkg, the carrier interface and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module image_transfer_draw_coord_regs_bench;
    import itd_pkg::*;
    logic ref_clk_i, srst_i, wr, word, go_bit_o, xfer_busy_o, pix_valid_o, irq_n, prev_irq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [10:0] dsx, dex, pix_x_o, pix_y_o, fx, lx, ly;
    logic [9:0] dsy, dey;
    logic [24:0] flash_rd_addr_o, fa, la;
    logic [15:0] ex [4];
    int fails = 0, n_tests = 0, cyc = 0, pix_n = 0, irq_low = 0, irq_cnt = 0;
    int seed = 32'hE7B1BD2E;

    itd_host_model host_u (.ref_clk_i(ref_clk_i), .host_wr_o(wr), .host_word_o(word),
        .host_addr_o(addr), .host_wdata_o(wdata));
    itd_regs dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .host_wr_i(wr),
        .host_word_i(word), .host_addr_i(addr), .host_wdata_i(wdata),
        .draw_start_x_o(dsx), .draw_start_y_o(dsy), .draw_end_x_o(dex), .draw_end_y_o(dey),
        .go_bit_o(go_bit_o), .xfer_busy_o(xfer_busy_o), .flash_rd_addr_o(flash_rd_addr_o),
        .pix_valid_o(pix_valid_o), .pix_x_o(pix_x_o), .pix_y_o(pix_y_o),
        .completion_irq_out_n_o(irq_n));

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic end_sim;
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Pixel and completion-pulse monitor, plus the hang limit.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (pix_valid_o === 1'b1) begin
            if (pix_n == 0) begin
                fa = flash_rd_addr_o;
                fx = pix_x_o;
            end
            la = flash_rd_addr_o;
            lx = pix_x_o;
            ly = pix_y_o;
            pix_n++;
        end
        if (irq_n === 1'b0) irq_low++;
        if (prev_irq === 1'b1 && irq_n === 1'b0) irq_cnt++;
        prev_irq = irq_n;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    function automatic logic [15:0] upd(input logic [15:0] o, input logic [15:0] d,
            input logic [1:0] m);
        if (m == 2'd0) return d;
        if (m == 2'd1) return {d[7:0], o[7:0]};
        return {o[15:8], d[7:0]};
    endfunction

    task automatic check_regs;
        @(posedge ref_clk_i);
        #1;
        check(dsx, ex[0][10:0]);
        check(dsy, ex[1][9:0]);
        check(dex, ex[2][10:0]);
        check(dey, ex[3][9:0]);
    endtask

    // With pulses at zero, wait for the completion pulse to fall; otherwise wait
    // until that many pulses were seen and the sequencer is idle again.
    task automatic wait_for(input int n, input int pulses);
        int k;
        k = 0;
        while (k < n && !(pulses > 0 ? (xfer_busy_o === 1'b0 && irq_cnt == pulses)
                : irq_n === 1'b0)) begin
            @(posedge ref_clk_i);
            #1;
            k++;
        end
    endtask

    task automatic xfer(input logic [24:0] lead, input logic [11:0] w, input logic [10:0] l,
            input logic [10:0] dx, input logic wd);
        int k;
        host_u.wr(23'h7FFFC6, {7'h00, lead[24:16]}, 1'b1);
        host_u.wr(23'h7FFFC8, lead[15:0], 1'b1);
        host_u.wr(23'h7FFFCA, {4'h0, w}, 1'b1);
        host_u.wr(23'h7FFFCC, {5'h00, l}, 1'b1);
        host_u.wr(23'h7FFFC2, {5'h00, dx}, 1'b1);
        pix_n = 0;
        irq_low = 0;
        irq_cnt = 0;
        host_u.wr(OFF_IMG_CTRL, wd ? 16'h0100 : 16'h0001, wd);
        k = 0;
        while (go_bit_o !== 1'b1 && k < 3) begin
            @(posedge ref_clk_i);
            #1;
            k++;
        end
        check(go_bit_o, 1);
        @(posedge ref_clk_i);
        #1;
        check(go_bit_o, 0);
        check(xfer_busy_o, 1);
    endtask

    initial begin
        logic [31:0] r;
        logic [24:0] lead;
        logic [11:0] w;
        logic [10:0] l, dx;
        srst_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1;
        srst_i = 1'b0;
        check({go_bit_o, xfer_busy_o, irq_n}, 3'b001);
        for (int i = 0; i < 4; i++) ex[i] = 16'h0000;
        check_regs();
        host_u.wr(23'h7FFFD8, 16'hFFFF, 1'b1);
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            if (r[3:2] == 2'd3) host_u.wr(23'h7FFFD1 + 23'(2 * r[1:0]), r[31:16], 1'b1);
            else begin
                host_u.wr(23'h7FFFD0 + 23'(2 * r[1:0]) + 23'(r[3:2] == 2'd2),
                    r[31:16], r[3:2] == 2'd0);
                ex[r[1:0]] = upd(ex[r[1:0]], r[31:16], r[3:2]);
            end
            check_regs();
        end
        for (int t = 0; t < 4; t++) begin
            lead = 25'($random(seed));
            w = 12'(($random(seed) & 3) + 1);
            l = 11'(($random(seed) & 1) + 1);
            dx = (t == 0) ? 11'h7FF : 11'($random(seed));
            xfer(lead, w, l, dx, t[0]);
            wait_for(200, 0);
            if (t == 3) begin
                // Start the next transfer from the completion handler.
                host_u.wr(OFF_IMG_CTRL, 16'h0001, 1'b0);
                check(go_bit_o, 1);
            end
            wait_for(400, (t == 3) ? 2 : 1);
            @(posedge ref_clk_i);
            #1;
            check(pix_n, (t == 3 ? 2 : 1) * w * l);
            check(irq_low, (t == 3 ? 2 : 1) * 10);
            check(irq_cnt, (t == 3) ? 2 : 1);
            check(fa, lead);
            check(fx, dx);
            check(la, 25'(lead + 25'(w * l) - 25'd1));
            check(lx, 11'(dx + w[10:0] - 11'd1));
            check(ly, l - 11'd1);
            check(go_bit_o, 0);
        end
        check_regs();
        // A control write whose go bit sits in the other lane must not start anything.
        host_u.wr(OFF_IMG_CTRL, 16'h0100, 1'b0);
        host_u.wr(OFF_IMG_CTRL, 16'h00FF, 1'b1);
        check({go_bit_o, xfer_busy_o}, 2'b00);
        // Reset in the middle of a transfer drops everything back to idle.
        xfer(25'h0000010, 12'h004, 11'h002, 11'h005, 1'b0);
        srst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        srst_i = 1'b0;
        check({go_bit_o, xfer_busy_o, irq_n, pix_valid_o}, 4'b0010);
        for (int i = 0; i < 4; i++) ex[i] = 16'h0000;
        check_regs();
        end_sim();
    end
endmodule
`default_nettype wire

// ### itd_host_model.sv
// Host CPU model that issues one-cycle byte or word writes on the register bus.
// Assumes the device samples the write strobe on the rising edge of ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module itd_host_model
    import itd_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Write bus toward the device
    output var logic host_wr_o,
    output var logic host_word_o,
    output var logic [itd_pkg::ADDR_W-1:0] host_addr_o,
    output var logic [itd_pkg::DATA_W-1:0] host_wdata_o
);
    initial begin
        host_wr_o = 1'b0;
        host_word_o = 1'b0;
        host_addr_o = '0;
        host_wdata_o = '0;
    end

    // Byte data rides on the low lane; after the strobe the bus shows inverted
    // values so that nothing can lean on stale address or data.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic w);
        @(posedge ref_clk_i);
        #1;
        host_wr_o = 1'b1;
        host_word_o = w;
        host_addr_o = a;
        host_wdata_o = d;
        @(posedge ref_clk_i);
        #1;
        host_wr_o = 1'b0;
        host_word_o = ~w;
        host_addr_o = ~a;
        host_wdata_o = ~d;
    endtask
endmodule
`default_nettype wire

// ### itd_param_if.sv
// Carrier between the register bank and the transfer sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface itd_param_if;
    logic start;
    logic accept;
    logic busy;
    logic [24:0] lead_addr;
    logic [11:0] width;
    logic [10:0] lines;
    logic [10:0] disp_x;

    modport regs (output start, lead_addr, width, lines, disp_x, input accept, busy);
    modport seq (input start, lead_addr, width, lines, disp_x, output accept, busy);
endinterface
`default_nettype wire

// ### itd_pkg.sv
// Package for the image transfer and drawing coordinate register bank.
// Assumes a 10 MHz single clock and a host bus with 23-bit byte addresses.
package itd_pkg;

    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int N_REGS = 9;

    // Register indices inside the parameter array.
    localparam int IDX_DISP_X = 0;
    localparam int IDX_FLASH_HI = 1;
    localparam int IDX_FLASH_LO = 2;
    localparam int IDX_WIDTH = 3;
    localparam int IDX_LINES = 4;
    localparam int IDX_DSX = 5;
    localparam int IDX_DSY = 6;
    localparam int IDX_DEX = 7;
    localparam int IDX_DEY = 8;

    // Byte addresses of the even (high) half of each parameter register.
    localparam logic [N_REGS-1:0][ADDR_W-1:0] REG_OFF = {
        23'h7FFFD6, 23'h7FFFD4, 23'h7FFFD2, 23'h7FFFD0, 23'h7FFFCC,
        23'h7FFFCA, 23'h7FFFC8, 23'h7FFFC6, 23'h7FFFC2
    };

    // Implemented bits of each register; the rest never store.
    localparam logic [N_REGS-1:0][DATA_W-1:0] REG_MASK = {
        16'h03FF, 16'h07FF, 16'h03FF, 16'h07FF, 16'h07FF,
        16'h0FFF, 16'hFFFF, 16'h01FF, 16'h07FF
    };

    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

    localparam logic [ADDR_W-1:0] OFF_IMG_CTRL = 23'h7FFFCE;
    localparam int GO_BYTE_BIT = 0;
    localparam int GO_WORD_BIT = 8;

    localparam int CLK_PERIOD_NS = 100;
    localparam int DONE_PULSE_NS = 1000;
    localparam int DONE_PULSE_CYC = (DONE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ITD_IDLE, ITD_RUN, ITD_DONE} itd_state_e;

endpackage

// ### itd_regs.sv
// Write-only parameter bank for image transfer and drawing coordinates.
// Assumes host writes are one-cycle strobes synchronous to ref_clk_i.
//
// What this block does
// RQ1: Holds an 11-bit image line count, reset zero, meaningful from 1 to 1024.
// RQ2: Stores written coordinates and sizes as given, with no clamping.
// RQ3: Each parameter register takes a byte to either half or a whole word.
// RQ4: Writing one to bit 8 of image control (bit 0 of a byte write) starts a transfer.
// RQ5: The go bit resets to zero and clears itself once the transfer begins.
// RQ6: Transfer completion gives one active-low pulse of about one microsecond.
// RQ7: Host may service the pulse as an interrupt and start the next transfer.
// RQ8: Holds an 11-bit drawing start X, reset zero.
// RQ9: Holds a 10-bit drawing start Y, reset zero.
// RQ10: Holds an 11-bit drawing end X, reset zero.
// RQ11: Holds a 10-bit drawing end Y, reset zero.
// RQ12: Drawing coordinates also feed the rectangle-fill and line-drawing engines.
// RQ13: Transfer reads flash from a programmed 25-bit lead address.
// RQ14: Transfer width in pixels comes from a programmed width field.
// RQ15: Transfer places the image at a programmed display start X.
// RQ16: Even byte address maps to bits 15:8, odd address to bits 7:0.
// RQ17: Unused upper bits ignore writes; the registers cannot be read back.
`timescale 1ns/1ps
`default_nettype none
module itd_regs
    import itd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Host write bus
    input wire logic host_wr_i,
    input wire logic host_word_i,
    input wire logic [itd_pkg::ADDR_W-1:0] host_addr_i,
    input wire logic [itd_pkg::DATA_W-1:0] host_wdata_i,
    // Drawing coordinates for fill and line engines
    output logic [10:0] draw_start_x_o,
    output logic [9:0] draw_start_y_o,
    output logic [10:0] draw_end_x_o,
    output logic [9:0] draw_end_y_o,
    // Image transfer status and pixel stream
    output logic go_bit_o,
    output logic xfer_busy_o,
    output logic [24:0] flash_rd_addr_o,
    output logic pix_valid_o,
    output logic [10:0] pix_x_o,
    output logic [10:0] pix_y_o,
    // Completion pulse, active low
    output logic completion_irq_out_n_o
);
    import itd_pkg::*;

    typedef struct packed {
        logic [N_REGS-1:0][DATA_W-1:0] prm;
        logic go_bit;
    } itd_regs_s;

    itd_regs_s q;
    itd_regs_s next_q;

    logic [N_REGS-1:0] wr_hi;
    logic [N_REGS-1:0] wr_lo;
    logic [DATA_W-1:0] wr_data;
    logic go_write;

    itd_param_if prm_if ();

    // Byte data travels on the low lane and is copied to whichever half it hits.
    assign wr_data = host_word_i ? host_wdata_i : {host_wdata_i[7:0], host_wdata_i[7:0]};

    genvar gi;
    generate
        for (gi = 0; gi < N_REGS; gi++) begin : g_dec
            // A word write at an odd address is ignored rather than split.
            assign wr_hi[gi] = host_wr_i && (host_addr_i == REG_OFF[gi]); // RQ16
            assign wr_lo[gi] = host_wr_i && ((host_word_i && host_addr_i == REG_OFF[gi])
                || (!host_word_i && host_addr_i == 23'(REG_OFF[gi] + 23'h000001))); // RQ3
        end
    endgenerate

    assign go_write = host_wr_i && (host_addr_i == OFF_IMG_CTRL)
        && (host_word_i ? host_wdata_i[GO_WORD_BIT] : host_wdata_i[GO_BYTE_BIT]);

    always_comb begin
        next_q = q;
        for (int i = 0; i < N_REGS; i++) begin
            if (wr_hi[i]) begin
                next_q.prm[i][15:8] = wr_data[15:8] & REG_MASK[i][15:8]; // RQ17
            end
            if (wr_lo[i]) begin
                next_q.prm[i][7:0] = wr_data[7:0] & REG_MASK[i][7:0]; // RQ2
            end
        end
        // The set beats the self-clear so a write landing on acceptance re-arms.
        if (go_write) begin
            next_q.go_bit = 1'b1; // RQ4
        end else if (prm_if.accept) begin
            next_q.go_bit = 1'b0; // RQ5
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q.prm <= {N_REGS{REG_RESET}}; // RQ1
            q.go_bit <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // A go written while a transfer runs waits until the sequencer is idle.
    assign prm_if.start = q.go_bit;
    assign prm_if.lead_addr = {q.prm[IDX_FLASH_HI][8:0], q.prm[IDX_FLASH_LO]};
    assign prm_if.width = q.prm[IDX_WIDTH][11:0];
    assign prm_if.lines = q.prm[IDX_LINES][10:0];
    assign prm_if.disp_x = q.prm[IDX_DISP_X][10:0];

    assign draw_start_x_o = q.prm[IDX_DSX][10:0]; // RQ8 RQ12
    assign draw_start_y_o = q.prm[IDX_DSY][9:0]; // RQ9
    assign draw_end_x_o = q.prm[IDX_DEX][10:0]; // RQ10
    assign draw_end_y_o = q.prm[IDX_DEY][9:0]; // RQ11
    assign go_bit_o = q.go_bit;
    assign xfer_busy_o = prm_if.busy;

    itd_xfer_seq u_seq (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .prm(prm_if.seq),
        .flash_rd_addr_o(flash_rd_addr_o),
        .pix_valid_o(pix_valid_o),
        .pix_x_o(pix_x_o),
        .pix_y_o(pix_y_o),
        .completion_irq_out_n_o(completion_irq_out_n_o)
    );

    a_byte_even_high: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ16
        (host_wr_i && !host_word_i && host_addr_i == 23'h7FFFD0)
        |=> draw_start_x_o[10:8] == $past(host_wdata_i[2:0]))
        else $error("even byte did not land in the high half");

    a_byte_odd_low: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ3
        (host_wr_i && !host_word_i && host_addr_i == 23'h7FFFD3)
        |=> draw_start_y_o[7:0] == $past(host_wdata_i[7:0])
            && draw_start_y_o[9:8] == $past(draw_start_y_o[9:8]))
        else $error("odd byte write disturbed or missed its half");

    a_word_no_clamp: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ2
        (host_wr_i && host_word_i && host_addr_i == 23'h7FFFD4)
        |=> draw_end_x_o == $past(host_wdata_i[10:0]))
        else $error("word write was not stored as given");

    a_unused_bits_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ17
        (q.prm[IDX_DEY] & ~REG_MASK[IDX_DEY]) == 16'h0000
        && (q.prm[IDX_LINES] & ~REG_MASK[IDX_LINES]) == 16'h0000)
        else $error("unused register bits were stored");

    a_go_sets: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ4
        go_write |=> go_bit_o ##[0:200] xfer_busy_o)
        else $error("go write did not start a transfer");

    a_go_self_clears: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ5
        (prm_if.accept && !go_write) |=> !go_bit_o && xfer_busy_o)
        else $error("go bit did not clear on transfer start");

    a_lines_loaded: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ1
        (host_wr_i && host_word_i && host_addr_i == 23'h7FFFCC)
        |=> prm_if.lines == $past(host_wdata_i[10:0]))
        else $error("line count word write not stored");

    a_reset_clear: assert property (@(posedge ref_clk_i) // RQ8
        srst_i |=> draw_start_x_o == 0 && draw_end_y_o == 0 && !go_bit_o
            && completion_irq_out_n_o)
        else $error("reset values wrong");

    a_word_even_both: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ3
        (host_wr_i && host_word_i && host_addr_i == REG_OFF[IDX_DSX])
        |=> draw_start_x_o == $past(host_wdata_i[10:0]))
        else $error("word write to start X not stored");

    a_word_odd_dropped: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ16
        (host_wr_i && host_word_i && host_addr_i == 23'(REG_OFF[IDX_DSX] + 23'h000001))
        |=> $stable(draw_start_x_o))
        else $error("word write at an odd address changed a register");

    a_start_y_word: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ9
        (host_wr_i && host_word_i && host_addr_i == REG_OFF[IDX_DSY])
        |=> draw_start_y_o == $past(host_wdata_i[9:0]))
        else $error("word write to start Y not stored");

    a_end_y_word: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ11
        (host_wr_i && host_word_i && host_addr_i == REG_OFF[IDX_DEY])
        |=> draw_end_y_o == $past(host_wdata_i[9:0]))
        else $error("word write to end Y not stored");

    a_end_y_byte: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ11
        (host_wr_i && !host_word_i && host_addr_i == REG_OFF[IDX_DEY])
        |=> draw_end_y_o[9:8] == $past(host_wdata_i[1:0])
            && draw_end_y_o[7:0] == $past(draw_end_y_o[7:0]))
        else $error("even byte to end Y missed or disturbed a half");

    a_width_loaded: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ14
        (host_wr_i && host_word_i && host_addr_i == REG_OFF[IDX_WIDTH])
        |=> prm_if.width == $past(host_wdata_i[11:0]))
        else $error("width word write not stored");

    a_lead_high_pair: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ13
        (host_wr_i && host_word_i && host_addr_i == REG_OFF[IDX_FLASH_HI])
        |=> prm_if.lead_addr[24:16] == $past(host_wdata_i[8:0]))
        else $error("upper lead address bits not stored");

    a_disp_x_loaded: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ15
        (host_wr_i && host_word_i && host_addr_i == REG_OFF[IDX_DISP_X])
        |=> prm_if.disp_x == $past(host_wdata_i[10:0]))
        else $error("display start X word write not stored");

    a_go_zero_ignored: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ4
        (host_wr_i && host_addr_i == OFF_IMG_CTRL && !go_write && !go_bit_o)
        |=> !go_bit_o)
        else $error("control write without the go bit set it");

    a_go_held_busy: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ5
        (go_bit_o && xfer_busy_o) |=> go_bit_o)
        else $error("go bit lost while a transfer was running");

endmodule
`default_nettype wire

// ### itd_xfer_seq.sv
// Image transfer sequencer: walks width by lines pixels from flash, then
// pulses the completion output low. Assumes parameters stay stable while busy.
`timescale 1ns/1ps
`default_nettype none
module itd_xfer_seq
    import itd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Parameters and start handshake
    itd_param_if.seq prm,
    // Pixel fetch stream
    output logic [24:0] flash_rd_addr_o,
    output logic pix_valid_o,
    output logic [10:0] pix_x_o,
    output logic [10:0] pix_y_o,
    // Completion pulse, active low
    output logic completion_irq_out_n_o
);
    import itd_pkg::*;

    typedef struct packed {
        itd_state_e state;
        logic [24:0] addr;
        logic [11:0] col;
        logic [10:0] row;
        logic [3:0] cnt;
        logic valid;
        logic irq_n;
        logic [24:0] rd_addr;
        logic [10:0] px;
        logic [10:0] py;
    } itd_seq_s;

    itd_seq_s q;
    itd_seq_s next_q;

    assign prm.accept = prm.start && (q.state == ITD_IDLE);
    assign prm.busy = (q.state != ITD_IDLE);
    assign flash_rd_addr_o = q.rd_addr;
    assign pix_valid_o = q.valid;
    assign pix_x_o = q.px;
    assign pix_y_o = q.py;
    assign completion_irq_out_n_o = q.irq_n;

    always_comb begin
        next_q = q;
        next_q.valid = 1'b0;
        case (q.state)
            ITD_IDLE: begin
                if (prm.accept) begin
                    next_q.state = ITD_RUN; // RQ4
                    next_q.addr = prm.lead_addr; // RQ13
                    next_q.col = 12'h000;
                    next_q.row = 11'h000;
                end
            end
            ITD_RUN: begin
                next_q.valid = 1'b1;
                next_q.rd_addr = q.addr;
                next_q.px = 11'(prm.disp_x + q.col); // RQ15
                next_q.py = q.row;
                next_q.addr = 25'(q.addr + 25'h0000001);
                // A zero width or line count wraps to the full counter range.
                if (q.col == 12'(prm.width - 12'h001)) begin // RQ14
                    next_q.col = 12'h000;
                    if (q.row == 11'(prm.lines - 11'h001)) begin // RQ1
                        next_q.state = ITD_DONE;
                        next_q.cnt = 4'(DONE_PULSE_CYC - 1);
                        next_q.irq_n = 1'b0; // RQ6
                    end else begin
                        next_q.row = 11'(q.row + 11'h001);
                    end
                end else begin
                    next_q.col = 12'(q.col + 12'h001);
                end
            end
            ITD_DONE: begin
                if (q.cnt == 4'h0) begin
                    next_q.irq_n = 1'b1;
                    next_q.state = ITD_IDLE;
                end else begin
                    next_q.cnt = 4'(q.cnt - 4'h1);
                end
            end
            default: begin
                next_q.state = ITD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q <= '0;
            q.state <= ITD_IDLE;
            q.irq_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    a_pulse_low_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ6
        $fell(q.irq_n) |-> (!q.irq_n) [*8] ##1 !q.irq_n ##1 !q.irq_n ##1 q.irq_n)
        else $error("completion pulse is not ten cycles low");

    a_start_loads_addr: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ13
        prm.accept |=> (q.state == ITD_RUN) && (q.addr == $past(prm.lead_addr)))
        else $error("start did not load the flash lead address");

    a_first_pixel_pos: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ15
        prm.accept |=> ##1 pix_valid_o && (pix_x_o == $past(prm.disp_x, 2)) && (pix_y_o == 0))
        else $error("first pixel not at display start");

    a_valid_in_run: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ4
        pix_valid_o |-> $past(q.state) == ITD_RUN)
        else $error("pixel valid outside a transfer");

endmodule
`default_nettype wire
